// >>> verilog/ebbc_defs.vh
`ifndef EBBC_DEFS_VH
`define EBBC_DEFS_VH

// Register indices (byte address = index)
`define EBBC_A_CFG        4'h0
`define EBBC_A_MONLOC     4'h1
`define EBBC_A_CLKMHZ     4'h2
`define EBBC_A_CMD        4'h3
`define EBBC_A_STATUS     4'h4
`define EBBC_A_RUNADDR    4'h5
`define EBBC_A_SEG        4'h6
`define EBBC_A_OFS        4'h7
`define EBBC_A_PC         4'h8

// Configuration bit positions
`define EBBC_C_CLKEXT     0
`define EBBC_C_RRT        1
`define EBBC_C_FGMON      2
`define EBBC_C_CYCVIS     3
`define EBBC_C_TRST       4
`define EBBC_C_NMI        5
`define EBBC_C_RAD_LO     6
`define EBBC_C_RAD_HI     7
`define EBBC_C_VAR_LO     8
`define EBBC_C_VAR_HI     9
`define EBBC_CFG_W        10
// Target reset enable set after power-up
`define EBBC_CFG_RESET    10'h010

// Conversion modes
`define EBBC_RAD_MAXSEG   2'h0
`define EBBC_RAD_MINSEG   2'h1
`define EBBC_RAD_CURSEG   2'h2

// Variants
`define EBBC_VAR_BASE     2'h0
`define EBBC_VAR_W32      2'h1
`define EBBC_VAR_W40      2'h2

// Clock limits in MHz
`define EBBC_INT_MHZ      8'h10
`define EBBC_BASE_MIN_MHZ 8'h02
`define EBBC_BASE_MAX_MHZ 8'h10
`define EBBC_EXT_MIN_MHZ  8'h04
`define EBBC_W32_MAX_MHZ  8'h20
`define EBBC_W40_MAX_MHZ  8'h28

// Commands
`define EBBC_CMD_RUN      3'h1
`define EBBC_CMD_BREAK    3'h2
`define EBBC_CMD_REGS     3'h3
`define EBBC_CMD_STEP     3'h4
`define EBBC_CMD_MEM      3'h5
`define EBBC_CMD_IO       3'h6

// Bus-status encodings for a visible background read
`define EBBC_MIO_MEM      1'b1
`define EBBC_ST1_READ     1'b0
`define EBBC_ST0_READ     1'b1
`define EBBC_RW_READ      1'b1
`define EBBC_ST2_READ     1'b1

// Address layout
`define EBBC_PAGE_MASK    24'hfff000
`define EBBC_RESET_VECTOR 24'h0ffff0
`define EBBC_MON_RESET    24'h000000

// Monitor states
`define EBBC_ST_FG        2'h0
`define EBBC_ST_BG        2'h1
`define EBBC_ST_FGMON     2'h2

`endif

// >>> verilog/ebbc_top.v
// How it works
// - Clock source internal 16 MHz or target
// - External clock range depends on variant
// - Real-time mode refuses target-access commands while running
// - Breaks enter background; foreground monitor follows when enabled
// - Data lines driven in background only on DMA cycles
// - Base visible cycles encode memory read
// - Base hidden cycles float status lines
// - Extended: address, extension, lock, refresh, hold driven
// - Extended visible cycles show memory read
// - Extended hidden cycles float status and strobes
// - DMA cycles drive everything, except extension, lock, refresh, hold on the base variant
// - Monitor location rounded down to 4K
// - Maxseg: low nibble offset, high four segment
// - Minseg: low four offset, top nibble segment
// - Curseg: value to counter, segment kept
// - Background ignores target reset
// - Accepted reset restarts at reset vector
// - Disabled target reset is ignored
// - Target interrupt gated by setting
// - Reads return setting, writes update it
`include "ebbc_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module ebbc_top
(
	input  wire        clk,
	input  wire        rst,
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	input  wire        bg_cycle,
	input  wire        dma_cycle,
	input  wire        tgt_reset,
	input  wire        tgt_nmi,
	input  wire        ext_clk_present,
	output reg         clk_sel_ext,
	output reg         clk_range_err,
	output reg         mon_background,
	output reg         mon_foreground,
	output reg         cmd_refused,
	output reg         running,
	output reg         cpu_reset,
	output reg         cpu_nmi,
	output reg  [23:0] fetch_addr,
	output reg  [23:0] mon_base,
	output reg         addr_oe,
	output reg         data_oe,
	output reg         cycle_start_strobe_oe,
	output reg         data_strobe_oe,
	output reg         mio_oe,
	output reg         mio_out,
	output reg         rw_oe,
	output reg         rw_out,
	output reg         bus_status_oe,
	output reg         bus_status_0,
	output reg         bus_status_1,
	output reg         bus_status_2,
	output reg         upper_byte_enable_oe,
	output reg         addr_ext_oe,
	output reg         bus_lock_out_oe,
	output reg         refresh_request_out_oe,
	output reg         hold_acknowledge_out_oe
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [`EBBC_CFG_W-1:0] cfg;
	reg [23:0]            mon_loc;
	reg [7:0]             clk_mhz;
	reg [23:0]            run_addr;
	reg [15:0]            seg_val;
	reg [15:0]            ofs_val;
	reg [15:0]            program_counter_reg;
	reg [15:0]            program_segment_reg;
	reg [1:0]             mon_state;
	reg                   tgt_reset_d;

	wire [1:0] rad     = cfg[`EBBC_C_RAD_HI:`EBBC_C_RAD_LO];
	wire [1:0] variant = cfg[`EBBC_C_VAR_HI:`EBBC_C_VAR_LO];
	wire       ext_var = (variant != `EBBC_VAR_BASE);
	wire       in_bg   = (mon_state == `EBBC_ST_BG);
	wire       wr_cmd  = reg_wr && (reg_addr == `EBBC_A_CMD);
	wire [2:0] cmd     = reg_wdata[2:0];
	wire       tgt_cmd = (cmd == `EBBC_CMD_REGS) || (cmd == `EBBC_CMD_STEP) ||
	                     (cmd == `EBBC_CMD_MEM) || (cmd == `EBBC_CMD_IO);
	wire       refuse  = wr_cmd && tgt_cmd && cfg[`EBBC_C_RRT] && running;
	wire       rst_ok  = cfg[`EBBC_C_TRST] && !in_bg;
	wire       rst_rel = tgt_reset_d && !tgt_reset && rst_ok;
	wire       nmi_ok  = tgt_nmi && cfg[`EBBC_C_NMI] && !in_bg;

	// ----------------------------------------
	// Clock range check
	// ----------------------------------------
	reg [7:0] next_min;
	reg [7:0] next_max;
	always @*
	begin
		next_min = `EBBC_EXT_MIN_MHZ;
		next_max = `EBBC_W40_MAX_MHZ;
		case (variant)
			`EBBC_VAR_BASE:
			begin
				next_min = `EBBC_BASE_MIN_MHZ;
				next_max = `EBBC_BASE_MAX_MHZ;
			end
			`EBBC_VAR_W32: next_max = `EBBC_W32_MAX_MHZ;
			default:       next_max = `EBBC_W40_MAX_MHZ;
		endcase
	end

	// ----------------------------------------
	// Run address conversion
	// ----------------------------------------
	reg [15:0] next_seg;
	reg [15:0] next_ofs;
	always @*
	begin
		next_seg = seg_val;
		next_ofs = ofs_val;
		case (rad)
			`EBBC_RAD_MAXSEG:
			begin
				next_seg = run_addr[19:4];
				next_ofs = {12'h000, run_addr[3:0]};
			end
			`EBBC_RAD_MINSEG:
			begin
				next_seg = {run_addr[19:16], 12'h000};
				next_ofs = run_addr[15:0];
			end
			`EBBC_RAD_CURSEG:
			begin
				next_seg = program_segment_reg;
				next_ofs = run_addr[15:0];
			end
			default:
			begin
				next_seg = seg_val;
				next_ofs = ofs_val;
			end
		endcase
	end

	// ----------------------------------------
	// Fetch address from segment and offset
	// ----------------------------------------
	// Segment times sixteen plus offset never needs more than 21 bits
	wire [23:0] next_fetch = {4'h0, next_seg, 4'h0} + {8'h00, next_ofs};

	// ----------------------------------------
	// Registers and monitor control
	// ----------------------------------------
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cfg                 <= `EBBC_CFG_RESET;
			mon_loc             <= `EBBC_MON_RESET;
			clk_mhz             <= `EBBC_INT_MHZ;
			run_addr            <= 24'h000000;
			seg_val             <= 16'h0000;
			ofs_val             <= 16'h0000;
			program_counter_reg <= 16'h0000;
			program_segment_reg <= 16'h0000;
			mon_state           <= `EBBC_ST_BG;
			tgt_reset_d         <= 1'b0;
			running             <= 1'b0;
			cmd_refused         <= 1'b0;
			cpu_reset           <= 1'b0;
			cpu_nmi             <= 1'b0;
			fetch_addr          <= `EBBC_RESET_VECTOR;
			reg_rdata           <= 32'h00000000;
		end
		else
		begin
			tgt_reset_d <= tgt_reset;
			cpu_nmi     <= 1'b0;
			if (refuse)
				cmd_refused <= 1'b1;
			else if (wr_cmd)
				cmd_refused <= 1'b0;
			if (reg_wr)
			begin
				case (reg_addr)
					`EBBC_A_CFG:     cfg <= reg_wdata[`EBBC_CFG_W-1:0];
					`EBBC_A_MONLOC:  mon_loc <= reg_wdata[23:0] & `EBBC_PAGE_MASK;
					`EBBC_A_CLKMHZ:  clk_mhz <= reg_wdata[7:0];
					`EBBC_A_RUNADDR: run_addr <= reg_wdata[23:0];
					`EBBC_A_PC:      program_counter_reg <= reg_wdata[15:0];
					`EBBC_A_SEG:     program_segment_reg <= reg_wdata[15:0];
					default:
					begin
					end
				endcase
			end
			if (wr_cmd && !refuse)
			begin
				case (cmd)
					`EBBC_CMD_RUN, `EBBC_CMD_STEP:
					begin
						seg_val             <= next_seg;
						ofs_val             <= next_ofs;
						program_counter_reg <= next_ofs;
						program_segment_reg <= next_seg;
						fetch_addr          <= next_fetch;
						running             <= (cmd == `EBBC_CMD_RUN);
						mon_state           <= `EBBC_ST_FG;
					end
					`EBBC_CMD_BREAK:
					begin
						running   <= 1'b0;
						mon_state <= `EBBC_ST_BG;
					end
					default:
					begin
					end
				endcase
			end
			else if (mon_state == `EBBC_ST_BG && cfg[`EBBC_C_FGMON] && !running)
				mon_state <= `EBBC_ST_FGMON;
			cpu_reset <= tgt_reset && rst_ok;
			if (rst_rel)
				fetch_addr <= `EBBC_RESET_VECTOR;
			if (nmi_ok)
				cpu_nmi <= 1'b1;
			reg_rdata <= 32'h00000000;
			if (reg_rd)
			begin
				case (reg_addr)
					`EBBC_A_CFG:     reg_rdata <= {22'h0, cfg};
					`EBBC_A_MONLOC:  reg_rdata <= {8'h00, mon_loc};
					`EBBC_A_CLKMHZ:  reg_rdata <= {24'h000000, clk_mhz};
					`EBBC_A_CMD:     reg_rdata <= {31'h0, cmd_refused};
					`EBBC_A_STATUS:  reg_rdata <= {28'h0000000, clk_range_err, running, mon_state};
					`EBBC_A_RUNADDR: reg_rdata <= {8'h00, run_addr};
					`EBBC_A_SEG:     reg_rdata <= {16'h0000, program_segment_reg};
					`EBBC_A_OFS:     reg_rdata <= {16'h0000, ofs_val};
					`EBBC_A_PC:      reg_rdata <= {16'h0000, program_counter_reg};
					default:         reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Clock select and target bus drive
	// ----------------------------------------
	wire vis        = cfg[`EBBC_C_CYCVIS];
	wire force_all  = bg_cycle && dma_cycle;
	wire bg_only    = bg_cycle && !dma_cycle;
	// Strobes float only on hidden cycles of the extended variants
	wire strobe_drv = bg_cycle && (!ext_var || vis || dma_cycle);
	// Status lines follow the visible setting unless a DMA cycle forces them
	wire status_drv = force_all || (bg_only && vis);

	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			clk_sel_ext             <= 1'b0;
			clk_range_err           <= 1'b0;
			mon_background          <= 1'b1;
			mon_foreground          <= 1'b0;
			mon_base                <= `EBBC_MON_RESET;
			addr_oe                 <= 1'b0;
			data_oe                 <= 1'b0;
			cycle_start_strobe_oe   <= 1'b0;
			data_strobe_oe          <= 1'b0;
			mio_oe                  <= 1'b0;
			mio_out                 <= 1'b0;
			rw_oe                   <= 1'b0;
			rw_out                  <= 1'b0;
			bus_status_oe           <= 1'b0;
			bus_status_0            <= 1'b0;
			bus_status_1            <= 1'b0;
			bus_status_2            <= 1'b0;
			upper_byte_enable_oe    <= 1'b0;
			addr_ext_oe             <= 1'b0;
			bus_lock_out_oe         <= 1'b0;
			refresh_request_out_oe  <= 1'b0;
			hold_acknowledge_out_oe <= 1'b0;
		end
		else
		begin
			clk_sel_ext    <= cfg[`EBBC_C_CLKEXT];
			clk_range_err  <= cfg[`EBBC_C_CLKEXT] &&
			                  (!ext_clk_present || clk_mhz < next_min || clk_mhz > next_max);
			mon_background <= (mon_state == `EBBC_ST_BG);
			mon_foreground <= (mon_state == `EBBC_ST_FGMON);
			mon_base       <= mon_loc;
			addr_oe                 <= bg_cycle;
			cycle_start_strobe_oe   <= strobe_drv;
			data_strobe_oe          <= strobe_drv;
			addr_ext_oe             <= bg_cycle && ext_var;
			bus_lock_out_oe         <= bg_cycle && ext_var;
			refresh_request_out_oe  <= bg_cycle && ext_var;
			hold_acknowledge_out_oe <= bg_cycle && ext_var;
			data_oe <= force_all;
			mio_oe               <= status_drv;
			rw_oe                <= status_drv;
			bus_status_oe        <= status_drv;
			// Upper-byte enable joins the visible status set on extended variants only; DMA cycles drive it on any variant
			upper_byte_enable_oe <= force_all || (bg_only && vis && ext_var);
			mio_out      <= `EBBC_MIO_MEM;
			rw_out       <= `EBBC_RW_READ;
			bus_status_0 <= `EBBC_ST0_READ;
			bus_status_1 <= `EBBC_ST1_READ;
			bus_status_2 <= `EBBC_ST2_READ;
		end
	end

endmodule // ebbc_top

`default_nettype wire

// >>> testbench/ebbc_target.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Target board: reset, interrupt and clock
// ----------------------------------------
module ebbc_target
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic rst_req,
	input  wire logic nmi_req,
	output var  logic tgt_reset,
	output var  logic tgt_nmi,
	output var  logic ext_clk_present
);
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tgt_reset       <= 1'b0;
			tgt_nmi         <= 1'b0;
			ext_clk_present <= 1'b0;
		end
		else
		begin
			tgt_reset       <= rst_req;
			tgt_nmi         <= nmi_req;
			ext_clk_present <= 1'b1;
		end
	end
endmodule // ebbc_target
`default_nettype wire

// >>> testbench/ebbc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ebbc_top_chk
(
	input wire logic        clk, rst, bg_cycle, dma_cycle, tgt_nmi, data_oe, addr_oe,
	input wire logic        mio_oe, mio_out, rw_oe, rw_out, bus_status_oe, bus_status_0, bus_status_1,
	input wire logic        mon_background, mon_foreground, cpu_reset, cpu_nmi, clk_sel_ext, clk_range_err,
	input wire logic [23:0] fetch_addr, mon_base
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_bg_dma;
		bg_cycle && dma_cycle;
	endsequence
	sequence s_drive_all;
		data_oe && addr_oe && mio_oe && rw_oe && bus_status_oe;
	endsequence
	chk_data_float:  assert property (bg_cycle && !dma_cycle |=> !data_oe) else $error("data driven");
	chk_addr_drive:  assert property (bg_cycle |=> addr_oe) else $error("address floats");
	chk_dma_all:     assert property (s_bg_dma |=> s_drive_all) else $error("dma not driven");
	chk_read_code:   assert property (mio_oe |-> mio_out && rw_out) else $error("bad read code");
	chk_status_code: assert property (bus_status_oe |-> bus_status_0 && !bus_status_1) else $error("bad status");
	chk_bg_reset:    assert property (mon_background && $past(mon_background) |-> !cpu_reset) else $error("bg reset");
	chk_reset_vec:   assert property ($fell(cpu_reset) |-> ##[0:1] fetch_addr == 24'h0ffff0) else $error("vector");
	chk_nmi_cause:   assert property (cpu_nmi |-> $past(tgt_nmi)) else $error("nmi no cause");
	chk_mon_round:   assert property (mon_base[11:0] == 12'h000) else $error("mon unaligned");
	chk_mon_state:   assert property (mon_foreground |-> !mon_background) else $error("two states");
	chk_clk_err:     assert property (!clk_sel_ext |-> !clk_range_err) else $error("clk error");
endmodule // ebbc_top_chk
bind ebbc_top ebbc_top_chk u_chk (.clk, .rst, .bg_cycle, .dma_cycle, .tgt_nmi, .data_oe, .addr_oe, .mio_oe,
	.mio_out, .rw_oe, .rw_out, .bus_status_oe, .bus_status_0, .bus_status_1, .mon_background, .mon_foreground,
	.cpu_reset, .cpu_nmi, .clk_sel_ext, .clk_range_err, .fetch_addr, .mon_base);
`default_nettype wire

// >>> testbench/ebbc_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ebbc_defs.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; $display("wrong value %0t %h", $time, a); end end
module ebbc_top_bench;
	logic        clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, bg_cycle = 0, dma_cycle = 0, rst_req = 0, nmi_req = 0;
	logic        rd_pend = 0, tgt_reset, tgt_nmi, ext_clk, cpu_reset, cpu_nmi, mio_oe, cs_oe, lock_oe, data_oe, ube_oe;
	logic [3:0]  reg_addr = 0;
	logic [31:0] reg_wdata = 0, seed = 32'h2056873f, a, reg_rdata, expq[$];
	logic [23:0] fetch_addr;
	int          n_fail = 0, num_checks = 0, i;
	ebbc_target u_tgt (.clk(clk), .rst(rst), .rst_req(rst_req), .nmi_req(nmi_req), .tgt_reset(tgt_reset),
		.tgt_nmi(tgt_nmi), .ext_clk_present(ext_clk));
	ebbc_top u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .bg_cycle(bg_cycle), .dma_cycle(dma_cycle), .tgt_reset(tgt_reset),
		.tgt_nmi(tgt_nmi), .ext_clk_present(ext_clk), .clk_sel_ext(), .clk_range_err(), .mon_background(),
		.mon_foreground(), .cmd_refused(), .running(), .cpu_reset(cpu_reset), .cpu_nmi(cpu_nmi),
		.fetch_addr(fetch_addr), .mon_base(), .addr_oe(), .data_oe(data_oe), .cycle_start_strobe_oe(cs_oe),
		.data_strobe_oe(), .mio_oe(mio_oe), .mio_out(), .rw_oe(), .rw_out(), .bus_status_oe(), .bus_status_0(),
		.bus_status_1(), .bus_status_2(), .upper_byte_enable_oe(ube_oe), .addr_ext_oe(), .bus_lock_out_oe(lock_oe),
		.refresh_request_out_oe(), .hold_acknowledge_out_oe());
	initial forever #20 clk = ~clk;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic wr(input logic [3:0] ad, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] ad, input logic [31:0] e);
		expq.push_back(e);
		@(posedge clk);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	task automatic bus(input logic dma, input logic [4:0] e);
		@(posedge clk);
		bg_cycle <= 1'b1;
		dma_cycle <= dma;
		repeat (2) @(posedge clk);
		`CHK({mio_oe, cs_oe, lock_oe, data_oe, ube_oe}, e)
		bg_cycle <= 1'b0;
		dma_cycle <= 1'b0;
	endtask
	task automatic finish_test();
		if (n_fail == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// Read data checker
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (rd_pend)
			`CHK(reg_rdata, expq.pop_front())
		rd_pend <= reg_rd;
	end
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rd(`EBBC_A_CFG, 32'h010);
		rd(`EBBC_A_CLKMHZ, 32'h10);
		a = lfsr(seed) & 32'hffffff;
		wr(`EBBC_A_MONLOC, a);
		rd(`EBBC_A_MONLOC, a & 32'hfff000);
		// External clock range check on the base variant
		wr(`EBBC_A_CFG, 32'h011);
		wr(`EBBC_A_CLKMHZ, 32'h11);
		rd(`EBBC_A_STATUS, 32'h9);
		wr(`EBBC_A_CLKMHZ, 32'h10);
		rd(`EBBC_A_STATUS, 32'h1);
		// Visible and hidden cycles on base and extended variants
		wr(`EBBC_A_CFG, 32'h018);
		bus(1'b0, 5'b11000);
		wr(`EBBC_A_CFG, 32'h010);
		bus(1'b0, 5'b01000);
		wr(`EBBC_A_CFG, 32'h118);
		bus(1'b0, 5'b11101);
		wr(`EBBC_A_CFG, 32'h110);
		bus(1'b0, 5'b00100);
		bus(1'b1, 5'b11111);
		// Conversion modes
		for (i = 0; i < 2; i++)
		begin
			seed = lfsr(seed);
			a = seed & 32'hfffff;
			wr(`EBBC_A_CFG, 32'h010 | (i << 6));
			wr(`EBBC_A_RUNADDR, a);
			wr(`EBBC_A_CMD, `EBBC_CMD_RUN);
			@(negedge clk);
			`CHK(fetch_addr, a[23:0])
			rd(`EBBC_A_SEG, i ? (a >> 4) & 32'hf000 : a >> 4);
			rd(`EBBC_A_OFS, i ? a & 32'hffff : a & 32'hf);
			rd(`EBBC_A_STATUS, 32'h4);
			wr(`EBBC_A_CMD, `EBBC_CMD_BREAK);
			rd(`EBBC_A_STATUS, 32'h1);
		end
		wr(`EBBC_A_SEG, 32'h1234);
		wr(`EBBC_A_CFG, 32'h090);
		wr(`EBBC_A_RUNADDR, 32'h5678);
		wr(`EBBC_A_CMD, `EBBC_CMD_STEP);
		rd(`EBBC_A_PC, 32'h5678);
		rd(`EBBC_A_SEG, 32'h1234);
		// Refusal only while running in real time
		wr(`EBBC_A_CMD, `EBBC_CMD_RUN);
		wr(`EBBC_A_CMD, `EBBC_CMD_REGS);
		rd(`EBBC_A_CMD, 32'h0);
		wr(`EBBC_A_CMD, `EBBC_CMD_BREAK);
		wr(`EBBC_A_CFG, 32'h032);
		wr(`EBBC_A_CMD, `EBBC_CMD_RUN);
		wr(`EBBC_A_CMD, `EBBC_CMD_MEM);
		rd(`EBBC_A_CMD, 32'h1);
		// Target reset and interrupt gating
		nmi_req <= 1'b1;
		rst_req <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK(cpu_reset, 1'b1)
		`CHK(cpu_nmi, 1'b1)
		rst_req <= 1'b0;
		for (i = 0; i < 8 && cpu_reset !== 1'b0; i++)
			@(posedge clk);
		`CHK(cpu_reset, 1'b0)
		`CHK(fetch_addr, 24'h0ffff0)
		wr(`EBBC_A_CFG, 32'h002);
		rst_req <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK({cpu_reset, cpu_nmi}, 2'b00)
		rst_req <= 1'b0;
		wr(`EBBC_A_CMD, `EBBC_CMD_BREAK);
		// Background ignores reset and interrupt even when both are enabled
		wr(`EBBC_A_CFG, 32'h030);
		rst_req <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK({cpu_reset, cpu_nmi}, 2'b00)
		rst_req <= 1'b0;
		nmi_req <= 1'b0;
		wr(`EBBC_A_CFG, 32'h014);
		wr(`EBBC_A_CMD, `EBBC_CMD_BREAK);
		rd(`EBBC_A_STATUS, 32'h2);
		repeat (3) @(posedge clk);
		`CHK(expq.size(), 0)
		finish_test();
	end
endmodule // ebbc_top_bench
`default_nettype wire
